// *** core/cwbp_pkg.sv ***
// Purpose: Constants for the configuration word and boot protection block
// Assumes: Byte addresses of the configuration space are 24 bits wide
// Notes:   Unprogrammed bits read as one, except boot word bits 7:4, which read as zero
package cwbp_pkg;
    localparam logic [23:0] CFG_SPACE_LO   = 24'h800000;
    localparam logic [23:0] ADDR_BOOT      = 24'hF80000;
    localparam logic [23:0] ADDR_GENERAL   = 24'hF80004;
    localparam logic [23:0] ADDR_OSC_SEL   = 24'hF80006;
    localparam logic [23:0] ADDR_OSC       = 24'hF80008;
    localparam logic [23:0] ADDR_WATCHDOG  = 24'hF8000A;
    localparam logic [23:0] ADDR_POR       = 24'hF8000C;
    localparam logic [23:0] ADDR_DEBUG     = 24'hF8000E;
    localparam logic [23:0] ADDR_REVISION  = 24'hFF0002;
    localparam logic [7:0]  CFG_ERASED     = 8'hFF;
    localparam logic [7:0]  BOOT_ERASED    = 8'h0F;
    localparam logic [7:0]  BOOT_IMPL_MASK = 8'h0F;
    localparam logic [23:0] RDATA_IDLE     = 24'h000000;
    localparam int          SELECT_LSB     = 1;
    localparam int          PROTECT_BIT    = 0;
    localparam logic [2:0]  SEL_NONE       = 3'h7;
    localparam logic [2:0]  SEL_SMALL_STD  = 3'h6;
    localparam logic [2:0]  SEL_SMALL_HIGH = 3'h2;
    localparam logic [2:0]  SEL_LARGE_STD  = 3'h5;
    localparam logic [2:0]  SEL_LARGE_HIGH = 3'h1;
    localparam logic [23:0] BOOT_START     = 24'h000200;
    localparam logic [23:0] BOOT_END_SMALL = 24'h000AFE;
    localparam logic [23:0] BOOT_END_LARGE = 24'h0015FE;
    localparam logic [3:0]  REVISION_DFLT  = 4'h1; // Arbitrary value
endpackage

// *** core/cwbp_config.sv ***
// Purpose: Configuration words, boot segment decode and protection
// Assumes: Table accesses arrive as single-cycle strobes on clk
// Notes:   Program writes arrive on a separate strobe for range checks
`timescale 1ns/1ns
`default_nettype none
module cwbp_config
    import cwbp_pkg::*;
#(
    parameter logic [3:0] MINOR_REVISION = REVISION_DFLT
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        tbl_rd,
    input  wire logic        tbl_wr,
    input  wire logic        fetch_rd,
    input  wire logic [23:0] tbl_addr,
    input  wire logic [7:0]  tbl_wdata,
    input  wire logic [23:0] exec_pc,
    input  wire logic        prog_wr,
    input  wire logic [23:0] prog_addr,
    output logic [23:0]      tbl_rdata,
    output logic             tbl_denied,
    output logic             prog_wr_allow,
    output logic             boot_active,
    output logic             boot_high_sec,
    output logic             select_reserved
);
    ////////////////////////////////////////////////////////////////////////
    // Word table: index 0 is the boot word, index 6 the debug word
    localparam int NWORDS = 7;
    localparam logic [23:0] WORD_ADDR [NWORDS] = '{ADDR_BOOT, ADDR_GENERAL,
        ADDR_OSC_SEL, ADDR_OSC, ADDR_WATCHDOG, ADDR_POR, ADDR_DEBUG};

    // Stored words and registered answers
    logic [7:0]        cfg_reg [NWORDS];
    logic [23:0]       tbl_rdata_reg;
    logic              tbl_denied_reg;
    logic              prog_wr_allow_reg;
    logic              boot_active_reg;
    logic              boot_high_sec_reg;
    logic              select_reserved_reg;
    logic [NWORDS-1:0] hit;
    logic [23:0]       rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // Fields of the boot word
    wire [2:0]  boot_segment_select = cfg_reg[0][SELECT_LSB +: 3];
    wire        boot_write_protect  = cfg_reg[0][PROTECT_BIT];

    // Segment size and security level from the select code
    wire        sel_small = (boot_segment_select == SEL_SMALL_STD) ||
                            (boot_segment_select == SEL_SMALL_HIGH);
    wire        sel_large = (boot_segment_select == SEL_LARGE_STD) ||
                            (boot_segment_select == SEL_LARGE_HIGH);
    wire        seg_valid = sel_small || sel_large;
    wire        seg_high  = (boot_segment_select == SEL_SMALL_HIGH) ||
                            (boot_segment_select == SEL_LARGE_HIGH);
    wire [23:0] seg_end   = sel_large ? BOOT_END_LARGE : BOOT_END_SMALL;
    // Reserved codes give no segment but are flagged
    wire        rsv_code  = !seg_valid && (boot_segment_select != SEL_NONE);

    ////////////////////////////////////////////////////////////////////////
    // Range checks; an inactive segment covers no address
    wire in_cfg_space = (tbl_addr >= CFG_SPACE_LO);
    wire tbl_in_boot  = seg_valid && (tbl_addr >= BOOT_START) && (tbl_addr <= seg_end);
    wire pc_in_boot   = seg_valid && (exec_pc >= BOOT_START) && (exec_pc <= seg_end);
    wire prog_in_boot = seg_valid && (prog_addr >= BOOT_START) && (prog_addr <= seg_end);
    wire is_rev       = (tbl_addr == ADDR_REVISION);

    // Refusals: secure reads from outside, fetches, protected writes
    wire rd_denied       = tbl_rd && tbl_in_boot && seg_high && !pc_in_boot;
    wire fetch_denied    = fetch_rd && in_cfg_space;
    wire wr_denied       = tbl_wr && tbl_in_boot && !boot_write_protect;
    wire tbl_denied_next = rd_denied || fetch_denied || wr_denied;
    wire prog_wr_next    = prog_wr && !(prog_in_boot && !boot_write_protect);

    ////////////////////////////////////////////////////////////////////////
    // Address decode and storage, one slice per word
    genvar g;
    generate
        for (g = 0; g < NWORDS; g++) begin : g_word
            assign hit[g] = (tbl_addr == WORD_ADDR[g]);
            // Erased after reset; a refused write leaves the word alone
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    cfg_reg[g] <= (g == 0) ? BOOT_ERASED : CFG_ERASED;
                end else if (tbl_wr && hit[g] && !tbl_denied_next) begin
                    cfg_reg[g] <= (g == 0) ? (tbl_wdata & BOOT_IMPL_MASK) : tbl_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data: one byte per word, revision zero-extended, else zero
    always_comb begin
        rdata_next = RDATA_IDLE;
        if (tbl_rd && !rd_denied) begin
            for (int i = 0; i < NWORDS; i++) begin
                if (hit[i]) begin
                    rdata_next = {16'h0000, cfg_reg[i]};
                end
            end
            if (is_rev) begin
                rdata_next = {20'h00000, MINOR_REVISION};
            end
        end
    end

    // Answers to the request of the previous cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tbl_rdata_reg     <= RDATA_IDLE;
            tbl_denied_reg    <= 1'b0;
            prog_wr_allow_reg <= 1'b0;
        end else begin
            tbl_rdata_reg     <= rdata_next;
            tbl_denied_reg    <= tbl_denied_next;
            prog_wr_allow_reg <= prog_wr_next;
        end
    end

    // Decoded levels follow the boot word one cycle late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_active_reg     <= 1'b0;
            boot_high_sec_reg   <= 1'b0;
            select_reserved_reg <= 1'b0;
        end else begin
            boot_active_reg     <= seg_valid;
            boot_high_sec_reg   <= seg_high;
            select_reserved_reg <= rsv_code;
        end
    end

    // Outputs straight from the registers
    assign tbl_rdata       = tbl_rdata_reg;
    assign tbl_denied      = tbl_denied_reg;
    assign prog_wr_allow   = prog_wr_allow_reg;
    assign boot_active     = boot_active_reg;
    assign boot_high_sec   = boot_high_sec_reg;
    assign select_reserved = select_reserved_reg;

    ////////////////////////////////////////////////////////////////////////
    // Protected segment refuses program writes
    a_boot_wr_block: assert property (
        @(posedge clk) disable iff (reset)
        prog_wr && prog_in_boot && !boot_write_protect |=> !prog_wr_allow)
        else $error("boot write passed while protected");

    // Writes outside the segment always pass
    a_outside_wr_ok: assert property (
        @(posedge clk) disable iff (reset)
        prog_wr && !prog_in_boot |=> prog_wr_allow)
        else $error("write outside boot refused");

    // Table writes into a protected segment are refused
    a_tbl_wr_block: assert property (
        @(posedge clk) disable iff (reset)
        tbl_wr && tbl_in_boot && !boot_write_protect |=> tbl_denied)
        else $error("table write into protected boot passed");

    // Boot word readback has its upper bits clear
    a_upper_zero: assert property (
        @(posedge clk) disable iff (reset)
        tbl_rd && tbl_addr == ADDR_BOOT |=> tbl_rdata[23:4] == 20'h00000)
        else $error("boot word upper bits set");

    // Revision word carries only the minor field
    a_rev_read: assert property (
        @(posedge clk) disable iff (reset)
        tbl_rd && is_rev |=> tbl_rdata == {20'h00000, MINOR_REVISION})
        else $error("revision read wrong");

    // Secure segment hides its contents from outside code
    a_high_sec_rd: assert property (
        @(posedge clk) disable iff (reset)
        tbl_rd && tbl_in_boot && seg_high && !pc_in_boot |=> tbl_denied && tbl_rdata == 24'h000000)
        else $error("secure boot read leaked");

    // Ordinary fetches never reach configuration space
    a_fetch_refused: assert property (
        @(posedge clk) disable iff (reset)
        fetch_rd && tbl_addr >= CFG_SPACE_LO |=> tbl_denied)
        else $error("fetch into config space allowed");

    // Last word of the table reads back its stored byte
    a_word_read: assert property (
        @(posedge clk) disable iff (reset)
        tbl_rd && tbl_addr == ADDR_DEBUG |=> tbl_rdata == {16'h0000, $past(cfg_reg[6])})
        else $error("debug word read wrong");

    // No-segment code leaves both levels low
    a_none_inactive: assert property (
        @(posedge clk) disable iff (reset)
        boot_segment_select == SEL_NONE |=> !boot_active && !select_reserved)
        else $error("no-segment code decoded");

    // Reserved codes are flagged and give no segment
    a_reserved_flag: assert property (
        @(posedge clk) disable iff (reset)
        rsv_code |=> select_reserved && !boot_active)
        else $error("reserved code not flagged");

    // Last word of the large segment is covered
    a_large_end: assert property (
        @(posedge clk) disable iff (reset)
        prog_wr && sel_large && !boot_write_protect && prog_addr == BOOT_END_LARGE |=> !prog_wr_allow)
        else $error("large segment end not protected");

    // First word past the small segment is free
    a_small_end: assert property (
        @(posedge clk) disable iff (reset)
        prog_wr && sel_small && !boot_write_protect && prog_addr == BOOT_END_SMALL + 24'h000002 |=> prog_wr_allow)
        else $error("small segment reaches too far");
endmodule
`default_nettype wire

// *** tb/cwbp_config_tb.sv ***
// Purpose: Self-checking bench for the configuration word block
// Assumes: Inputs change at the falling edge, answers stand one cycle
// Notes:   Minor revision set to A so a stuck default shows
`timescale 1ns/1ns
`default_nettype none
module cwbp_config_tb;
    import cwbp_pkg::*;
    logic        clk = 0, reset = 1, rd = 0, wr = 0, fe = 0, pw = 0;
    logic [23:0] addr = 0, pc = 0, paddr = 0, rdata;
    logic [7:0]  wd = 0;
    logic        den, pallow, bact, bhs, bres;
    int          mismatches = 0, checks_done = 0;
    cwbp_config #(.MINOR_REVISION(4'hA)) dut_u (.clk(clk), .reset(reset), .tbl_rd(rd), .tbl_wr(wr),
        .fetch_rd(fe), .tbl_addr(addr), .tbl_wdata(wd), .exec_pc(pc), .prog_wr(pw), .prog_addr(paddr),
        .tbl_rdata(rdata), .tbl_denied(den), .prog_wr_allow(pallow), .boot_active(bact),
        .boot_high_sec(bhs), .select_reserved(bres));
    // Clock at 100 ns period
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request cycle; answer is sampled while it stands
    task automatic op(input logic r, w, f, p, input logic [23:0] a, input logic [7:0] d);
        @(negedge clk);
        {rd, wr, fe, pw} = {r, w, f, p};
        addr = a;
        paddr = a;
        wd = d;
        @(negedge clk);
        {rd, wr, fe, pw} = 4'h0;
    endtask
    // Erased words, unmapped hole and revision word
    task automatic t_words();
        for (int i = 0; i < 8; i++) begin
            op(1, 0, 0, 0, ADDR_BOOT + 24'(2 * i), 8'h00);
            chk(rdata, (i == 1) ? 24'h0 : (i == 0) ? 24'h00000F : 24'h0000FF);
        end
        op(0, 1, 0, 0, ADDR_REVISION, 8'h05);
        op(1, 0, 0, 0, ADDR_REVISION, 8'h00);
        chk(rdata, 24'h00000A);
    endtask
    // Every select code, decoded levels and masked readback
    task automatic t_codes();
        logic [2:0] lv;
        for (int c = 0; c < 8; c++) begin
            op(0, 1, 0, 0, ADDR_BOOT, {4'hF, 3'(c), 1'b1});
            op(1, 0, 0, 0, ADDR_BOOT, 8'h00);
            chk(rdata, {19'h0, 1'b0, 3'(c), 1'b1});
            lv = {c == 1 || c == 2 || c == 5 || c == 6, c == 1 || c == 2, c == 0 || c == 3 || c == 4};
            chk({bact, bhs, bres}, lv);
        end
    endtask
    // Program writes against segment bounds and the protect bit
    task automatic prog(input logic [23:0] a, input logic exp);
        op(0, 0, 0, 1, a, 8'h00);
        chk(pallow, exp);
    endtask
    task automatic t_prot();
        op(0, 1, 0, 0, ADDR_BOOT, 8'h0C);
        op(0, 1, 0, 0, 24'h000400, 8'h00);
        chk(den, 1);
        prog(24'h000200, 0);
        prog(24'h000AFE, 0);
        prog(24'h000B00, 1);
        prog(24'h0001FE, 1);
        op(0, 1, 0, 0, ADDR_BOOT, 8'h0A);
        prog(24'h0015FE, 0);
        prog(24'h001600, 1);
        op(0, 1, 0, 0, ADDR_BOOT, 8'h0B);
        prog(24'h000400, 1);
        op(0, 1, 0, 0, 24'h000400, 8'h00);
        chk(den, 0);
    endtask
    // High security reads and fetches into configuration space
    task automatic rdchk(input logic [23:0] p, a, input logic f, exp);
        pc = p;
        op(!f, 0, f, 0, a, 8'h00);
        chk(den, exp);
    endtask
    task automatic t_deny();
        op(0, 1, 0, 0, ADDR_BOOT, 8'h05);
        rdchk(24'h003000, 24'h000400, 0, 1);
        rdchk(24'h000300, 24'h000400, 0, 0);
        op(0, 1, 0, 0, ADDR_BOOT, 8'h0D);
        rdchk(24'h003000, 24'h000400, 0, 0);
        rdchk(24'h000300, ADDR_BOOT, 1, 1);
        chk(rdata, 24'h0);
        rdchk(24'h000300, CFG_SPACE_LO - 24'h2, 1, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        reset = 0;
        t_words();
        t_codes();
        t_prot();
        t_deny();
        print_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #300000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
